//--- pkg/mcx_map.svh
`ifndef MCX_MAP_SVH
`define MCX_MAP_SVH

// control register addresses
`define MCX_CR_AMR 5'h00
`define MCX_CR_CSR 5'h01
`define MCX_CR_IFR 5'h02
`define MCX_CR_ISR 5'h02
`define MCX_CR_ICR 5'h03
`define MCX_CR_IER 5'h04
`define MCX_CR_VECTOR_TABLE_BASE 5'h05
`define MCX_CR_IRP 5'h06
`define MCX_CR_NRP 5'h07
`define MCX_CR_PCE 5'h10
`define MCX_CR_FP_ADDER_CFG 5'h12
`define MCX_CR_FP_AUXILIARY_CFG 5'h13
`define MCX_CR_FP_MULTIPLIER_CFG 5'h14

// reserved top six bits of the addressing mode register
`define MCX_AMR_WR_MASK 32'h03FF_FFFF
`define MCX_CR_RESET 32'h0000_0000

// opfields
`define MCX_OPF_COPY_L 7'h02
`define MCX_OPF_COPY_L_LONG 7'h21
`define MCX_OPF_COPY_D 7'h12
`define MCX_OPF_COPY_S 7'h06
`define MCX_OPF_NEG_S 7'h16
`define MCX_OPF_NEG_L 7'h06
`define MCX_OPF_NEG_L_LONG 7'h24
`define MCX_OPF_CTRL_RD 7'h0F
`define MCX_OPF_CTRL_WR 7'h0E

// idle and flag delay counts
`define MCX_NOP_MAX_COUNT 4'h9
`define MCX_FLAG_DELAY_CYCLES 2

`endif

//--- pkg/mcx_pkg.sv
package mcx_pkg;

	typedef enum logic [2:0] {
		first_side_logic_unit = 3'h0,
		second_side_logic_unit = 3'h1,
		first_side_shift_unit = 3'h2,
		second_side_shift_unit = 3'h3,
		first_side_data_unit = 3'h4,
		second_side_data_unit = 3'h5
	} mcx_unit_type;

	typedef enum logic [2:0] {
		mcx_cls_alu_op = 3'h0,
		mcx_cls_ctrl_transfer_op = 3'h1,
		mcx_cls_signed_const_load_op = 3'h2,
		mcx_cls_high_half_const_load_op = 3'h3,
		mcx_cls_low_to_high_const_load_op = 3'h4,
		mcx_cls_nop = 3'h5
	} mcx_class_type;

	typedef enum logic [1:0] {
		mcx_st_run = 2'b00,
		mcx_st_idle = 2'b01
	} mcx_state_type;

endpackage

//--- rtl/mcx_ctrl_regs.sv
`timescale 1ns/1ns
`include "mcx_map.svh"

module mcx_ctrl_regs
	import mcx_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [4:0] rd_addr,
	output logic [31:0] rd_data,
	input wire logic [31:0] hw_flag_set,
	input wire logic [31:0] pc_e1,
	output logic [31:0] addressing_mode_cfg,
	output logic [31:0] control_status,
	output logic [31:0] interrupt_flags,
	output logic [31:0] interrupt_enable_mask
);

	logic [31:0] amr_q, csr_q, ifr_q, ier_q, vector_table_base_q, irp_q, nrp_q;
	logic [31:0] fp_adder_cfg_q, fp_auxiliary_cfg_q, fp_multiplier_cfg_q;
	logic [31:0] set_pend_q, clr_pend_q;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			amr_q <= `MCX_CR_RESET;
			csr_q <= `MCX_CR_RESET;
			ier_q <= `MCX_CR_RESET;
			vector_table_base_q <= `MCX_CR_RESET;
			irp_q <= `MCX_CR_RESET;
			nrp_q <= `MCX_CR_RESET;
			fp_adder_cfg_q <= `MCX_CR_RESET;
			fp_auxiliary_cfg_q <= `MCX_CR_RESET;
			fp_multiplier_cfg_q <= `MCX_CR_RESET;
		end else if (wr_en) begin
			case (wr_addr)
				`MCX_CR_AMR: amr_q <= (wr_data & `MCX_AMR_WR_MASK) | (amr_q & ~`MCX_AMR_WR_MASK);
				`MCX_CR_CSR: csr_q <= wr_data;
				`MCX_CR_IER: ier_q <= wr_data;
				`MCX_CR_VECTOR_TABLE_BASE: vector_table_base_q <= wr_data;
				`MCX_CR_IRP: irp_q <= wr_data;
				`MCX_CR_NRP: nrp_q <= wr_data;
				`MCX_CR_FP_ADDER_CFG: fp_adder_cfg_q <= wr_data;
				`MCX_CR_FP_AUXILIARY_CFG: fp_auxiliary_cfg_q <= wr_data;
				`MCX_CR_FP_MULTIPLIER_CFG: fp_multiplier_cfg_q <= wr_data;
				default: begin
				end
			endcase
		end
	end

	// set/clear writes are staged one cycle so a flag read sees them two cycles on
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			set_pend_q <= `MCX_CR_RESET;
			clr_pend_q <= `MCX_CR_RESET;
		end else begin
			set_pend_q <= (wr_en && wr_addr == `MCX_CR_ISR) ? wr_data : `MCX_CR_RESET;
			clr_pend_q <= (wr_en && wr_addr == `MCX_CR_ICR) ? wr_data : `MCX_CR_RESET;
		end
	end

	// a set from either source wins over a clear in the same cycle
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ifr_q <= `MCX_CR_RESET;
		end else begin
			ifr_q <= (ifr_q & ~clr_pend_q) | set_pend_q | hw_flag_set;
		end
	end

	always_comb begin
		case (rd_addr)
			`MCX_CR_AMR: rd_data = amr_q & `MCX_AMR_WR_MASK;
			`MCX_CR_CSR: rd_data = csr_q;
			`MCX_CR_IFR: rd_data = ifr_q;
			`MCX_CR_IER: rd_data = ier_q;
			`MCX_CR_VECTOR_TABLE_BASE: rd_data = vector_table_base_q;
			`MCX_CR_IRP: rd_data = irp_q;
			`MCX_CR_NRP: rd_data = nrp_q;
			`MCX_CR_PCE: rd_data = pc_e1;
			`MCX_CR_FP_ADDER_CFG: rd_data = fp_adder_cfg_q;
			`MCX_CR_FP_AUXILIARY_CFG: rd_data = fp_auxiliary_cfg_q;
			`MCX_CR_FP_MULTIPLIER_CFG: rd_data = fp_multiplier_cfg_q;
			default: rd_data = `MCX_CR_RESET;
		endcase
	end

	assign addressing_mode_cfg = amr_q & `MCX_AMR_WR_MASK;
	assign control_status = csr_q;
	assign interrupt_flags = ifr_q;
	assign interrupt_enable_mask = ier_q;

endmodule

//--- rtl/mcx_unit.sv
`timescale 1ns/1ns
`include "mcx_map.svh"

// Summary of operation
// - register copy is computed as zero plus the source, written to destination.
// - register copy opfields per unit: logic 02, logic long 21, data 12, shift 06.
// - control transfers are accepted only on the second-side shift unit.
// - opfield 0F copies the addressed control register into the destination.
// - opfield 0E copies a general source, cross path allowed, into a control register.
// - control registers use 5-bit addresses; 00010 reads flags, writes set flags.
// - set or clear writes appear in a flag read two cycles after the write.
// - the six top bits of the addressing mode register are never written.
// - signed constant load sign-extends 16 bits to 32 on either shift unit.
// - upper-half loads put the immediate in bits 31..16, keeping bits 15..0.
// - negate is zero minus source; opfields shift 16, logic 06, logic long 24.
// - no-op field holds count minus one; empty no-op is 0000; count at most 9.
// - a multicycle no-op ends early when an earlier branch completes.
module mcx_unit
	import mcx_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic op_valid,
	input wire mcx_class_type op_class,
	input wire mcx_unit_type op_unit,
	input wire logic [6:0] op_opfield,
	input wire logic op_cond_pass,
	input wire logic [39:0] op_src_data,
	input wire logic [15:0] op_imm,
	input wire logic [3:0] op_nop_field,
	input wire logic [31:0] op_dst_old,
	input wire logic [4:0] op_dst_addr,
	input wire logic [4:0] op_ctrl_addr,
	input wire logic branch_done,
	input wire logic [31:0] hw_flag_set,
	input wire logic [31:0] pc_e1,
	output logic rf_we,
	output logic rf_long,
	output logic [4:0] rf_waddr,
	output logic [39:0] rf_wdata,
	output logic op_illegal,
	output logic nop_busy,
	output logic [31:0] addressing_mode_cfg,
	output logic [31:0] control_status,
	output logic [31:0] interrupt_flags,
	output logic [31:0] interrupt_enable_mask
);

	// unit grouping shared by the pseudo-operation and constant-load decoders below
	function automatic logic is_logic_unit(input mcx_unit_type u);
		is_logic_unit = (u == first_side_logic_unit) || (u == second_side_logic_unit);
	endfunction

	function automatic logic is_shift_unit(input mcx_unit_type u);
		is_shift_unit = (u == first_side_shift_unit) || (u == second_side_shift_unit);
	endfunction

	function automatic logic is_data_unit(input mcx_unit_type u);
		is_data_unit = (u == first_side_data_unit) || (u == second_side_data_unit);
	endfunction

	// the write-only set address shares the flag read address
	function automatic logic ctrl_readable(input logic [4:0] a);
		case (a)
			`MCX_CR_AMR,
			`MCX_CR_CSR,
			`MCX_CR_IFR,
			`MCX_CR_IER,
			`MCX_CR_VECTOR_TABLE_BASE,
			`MCX_CR_IRP,
			`MCX_CR_NRP,
			`MCX_CR_PCE,
			`MCX_CR_FP_ADDER_CFG,
			`MCX_CR_FP_AUXILIARY_CFG,
			`MCX_CR_FP_MULTIPLIER_CFG: ctrl_readable = 1'b1;
			default: ctrl_readable = 1'b0;
		endcase
	endfunction

	// the flag register itself is read-only; only the set and clear addresses reach it
	function automatic logic ctrl_writable(input logic [4:0] a);
		case (a)
			`MCX_CR_AMR,
			`MCX_CR_CSR,
			`MCX_CR_ISR,
			`MCX_CR_ICR,
			`MCX_CR_IER,
			`MCX_CR_VECTOR_TABLE_BASE,
			`MCX_CR_IRP,
			`MCX_CR_NRP,
			`MCX_CR_FP_ADDER_CFG,
			`MCX_CR_FP_AUXILIARY_CFG,
			`MCX_CR_FP_MULTIPLIER_CFG: ctrl_writable = 1'b1;
			default: ctrl_writable = 1'b0;
		endcase
	endfunction

	mcx_state_type state_q;
	mcx_state_type state_d;
	logic [3:0] idle_left_q;
	logic [3:0] idle_left_d;
	logic take;
	logic exec;
	logic is_copy;
	logic is_neg;
	logic is_long;
	logic alu_ok;
	logic ctrl_rd;
	logic ctrl_wr;
	logic ctrl_ok;
	logic const_ok;
	logic nop_ok;
	logic [39:0] src_ext;
	logic [39:0] alu_res;
	logic [39:0] res_d;
	logic we_d;
	logic illegal_d;
	logic [31:0] cr_rd_data;
	logic cr_wr_en;
	logic rf_we_q;
	logic rf_long_q;
	logic op_illegal_q;
	logic [4:0] rf_waddr_q;
	logic [39:0] rf_wdata_q;

	// while a multicycle no-op idles, the issue stage must hold its instruction
	assign take = op_valid && (state_q == mcx_st_run);
	assign exec = take && op_cond_pass;

	// pseudo-operation decode by unit and opfield
	always_comb begin
		is_copy = 1'b0;
		is_neg = 1'b0;
		is_long = 1'b0;
		if (is_logic_unit(op_unit)) begin
			case (op_opfield)
				`MCX_OPF_COPY_L: is_copy = 1'b1;
				`MCX_OPF_COPY_L_LONG: begin
					is_copy = 1'b1;
					is_long = 1'b1;
				end
				`MCX_OPF_NEG_L: is_neg = 1'b1;
				`MCX_OPF_NEG_L_LONG: begin
					is_neg = 1'b1;
					is_long = 1'b1;
				end
				default: begin
				end
			endcase
		end else if (is_shift_unit(op_unit)) begin
			case (op_opfield)
				`MCX_OPF_COPY_S: is_copy = 1'b1;
				`MCX_OPF_NEG_S: is_neg = 1'b1;
				default: begin
				end
			endcase
		end else if (is_data_unit(op_unit)) begin
			case (op_opfield)
				`MCX_OPF_COPY_D: is_copy = 1'b1;
				default: begin
				end
			endcase
		end
	end

	// anything in the alu class that is neither copy nor negate is refused
	assign alu_ok = (op_class == mcx_cls_alu_op) && (is_copy || is_neg);

	// 32-bit operands are sign-extended so one 40-bit adder serves both widths
	assign src_ext = is_long ? op_src_data : {{8{op_src_data[31]}}, op_src_data[31:0]};

	always_comb begin
		if (is_neg) begin
			alu_res = 40'h00_0000_0000 - src_ext;
		end else begin
			alu_res = 40'h00_0000_0000 + src_ext;
		end
		if (!is_long) begin
			alu_res[39:32] = 8'h00;
		end
	end

	// control transfer decode
	always_comb begin
		ctrl_rd = 1'b0;
		ctrl_wr = 1'b0;
		if (op_class == mcx_cls_ctrl_transfer_op && op_unit == second_side_shift_unit) begin
			case (op_opfield)
				`MCX_OPF_CTRL_RD: ctrl_rd = ctrl_readable(op_ctrl_addr);
				`MCX_OPF_CTRL_WR: ctrl_wr = ctrl_writable(op_ctrl_addr);
				default: begin
				end
			endcase
		end
	end

	// a refused transfer neither writes nor reads, but still reports illegal
	assign ctrl_ok = ctrl_rd || ctrl_wr;
	assign cr_wr_en = exec && ctrl_wr;

	// constant loads exist only on the shift units of either side
	assign const_ok = ((op_class == mcx_cls_signed_const_load_op)
		|| (op_class == mcx_cls_high_half_const_load_op)
		|| (op_class == mcx_cls_low_to_high_const_load_op)) && is_shift_unit(op_unit);

	// field values above count nine are refused
	assign nop_ok = (op_class == mcx_cls_nop) && (op_nop_field < `MCX_NOP_MAX_COUNT);

	// result selection, all within one cycle
	always_comb begin
		res_d = 40'h00_0000_0000;
		we_d = 1'b0;
		illegal_d = 1'b0;
		case (op_class)
			mcx_cls_alu_op: begin
				res_d = alu_res;
				we_d = alu_ok;
				illegal_d = !alu_ok;
			end
			mcx_cls_ctrl_transfer_op: begin
				res_d = {8'h00, cr_rd_data};
				we_d = ctrl_rd;
				illegal_d = !ctrl_ok;
			end
			mcx_cls_signed_const_load_op: begin
				res_d = {8'h00, {16{op_imm[15]}}, op_imm};
				we_d = const_ok;
				illegal_d = !const_ok;
			end
			mcx_cls_high_half_const_load_op, mcx_cls_low_to_high_const_load_op: begin
				res_d = {8'h00, op_imm, op_dst_old[15:0]};
				we_d = const_ok;
				illegal_d = !const_ok;
			end
			mcx_cls_nop: begin
				illegal_d = !nop_ok;
			end
			default: begin
				illegal_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rf_we_q <= 1'b0;
			rf_long_q <= 1'b0;
		end else begin
			rf_we_q <= exec && we_d;
			rf_long_q <= exec && we_d && is_long && (op_class == mcx_cls_alu_op);
		end
	end

	// address and data hold until the next write so a late reader still sees them
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rf_waddr_q <= 5'h00;
			rf_wdata_q <= 40'h00_0000_0000;
		end else begin
			if (exec && we_d) begin
				rf_waddr_q <= op_dst_addr;
				rf_wdata_q <= res_d;
			end
		end
	end

	// illegal reports even when the condition fails: the encoding itself is bad
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_illegal_q <= 1'b0;
		end else begin
			op_illegal_q <= take && illegal_d;
		end
	end

	// multicycle no-op: the issue cycle is the first idle cycle
	always_comb begin
		state_d = state_q;
		idle_left_d = idle_left_q;
		case (state_q)
			mcx_st_run: begin
				if (take && nop_ok && op_nop_field != 4'h0 && !branch_done) begin
					state_d = mcx_st_idle;
					idle_left_d = op_nop_field;
				end
			end
			mcx_st_idle: begin
				if (branch_done || idle_left_q == 4'h1) begin
					state_d = mcx_st_run;
					idle_left_d = 4'h0;
				end else begin
					idle_left_d = idle_left_q - 4'h1;
				end
			end
			default: begin
				state_d = mcx_st_run;
				idle_left_d = 4'h0;
			end
		endcase
	end

	// the field holds count minus one, and the issue cycle supplies the missing one
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= mcx_st_run;
			idle_left_q <= 4'h0;
		end else begin
			state_q <= state_d;
			idle_left_q <= idle_left_d;
		end
	end

	mcx_ctrl_regs u_ctrl_regs (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.wr_en(cr_wr_en),
		.wr_addr(op_ctrl_addr),
		.wr_data(op_src_data[31:0]),
		.rd_addr(op_ctrl_addr),
		.rd_data(cr_rd_data),
		.hw_flag_set(hw_flag_set),
		.pc_e1(pc_e1),
		.addressing_mode_cfg(addressing_mode_cfg),
		.control_status(control_status),
		.interrupt_flags(interrupt_flags),
		.interrupt_enable_mask(interrupt_enable_mask)
	);

	assign rf_we = rf_we_q;
	assign rf_long = rf_long_q;
	assign rf_waddr = rf_waddr_q;
	assign rf_wdata = rf_wdata_q;
	assign op_illegal = op_illegal_q;
	// straight from the state flop so the issue stage sees it in the same cycle
	assign nop_busy = (state_q == mcx_st_idle);

endmodule

//--- sim/mcx_unit_sva.sv
`timescale 1ns/1ns
module mcx_unit_sva
	import mcx_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic op_valid,
	input wire mcx_class_type op_class,
	input wire mcx_unit_type op_unit,
	input wire logic [6:0] op_opfield,
	input wire logic op_cond_pass,
	input wire logic [39:0] op_src_data,
	input wire logic [15:0] op_imm,
	input wire logic [3:0] op_nop_field,
	input wire logic [31:0] op_dst_old,
	input wire logic [4:0] op_ctrl_addr,
	input wire logic branch_done,
	input wire logic rf_we,
	input wire logic rf_long,
	input wire logic [39:0] rf_wdata,
	input wire logic op_illegal,
	input wire logic nop_busy,
	input wire logic [31:0] addressing_mode_cfg,
	input wire logic [31:0] interrupt_flags
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire logic tk = op_valid && !nop_busy && op_cond_pass;
	wire logic l_u = op_unit inside {first_side_logic_unit, second_side_logic_unit};
	wire logic s_u = op_unit inside {first_side_shift_unit, second_side_shift_unit};
	wire logic alu = tk && op_class == mcx_cls_alu_op;
	wire logic ctl = tk && op_class == mcx_cls_ctrl_transfer_op && op_unit == second_side_shift_unit;

	a_copy_value: assert property (alu && l_u && op_opfield == 7'h02
		|=> rf_we && rf_wdata == {8'h00, $past(op_src_data[31:0])}) else $error("copy result wrong");
	a_neg_long: assert property (alu && l_u && op_opfield == 7'h24
		|=> rf_long && rf_wdata == 40'h00_0000_0000 - $past(op_src_data)) else $error("long negate wrong");
	a_ctrl_unit_only: assert property (op_valid && !nop_busy && op_class == mcx_cls_ctrl_transfer_op
		&& op_unit != second_side_shift_unit |=> op_illegal && !rf_we) else $error("transfer on wrong unit");
	a_ctrl_read_amr: assert property (ctl && op_opfield == 7'h0F && op_ctrl_addr == 5'h00
		|=> rf_we && rf_wdata == {8'h00, addressing_mode_cfg}) else $error("control read wrong");
	a_amr_write: assert property (ctl && op_opfield == 7'h0E && op_ctrl_addr == 5'h00
		|=> addressing_mode_cfg == {6'h00, $past(op_src_data[25:0])}) else $error("mode register write wrong");
	// a clear issued one cycle later lands after this check, so set bits must still be seen
	a_flag_delay: assert property (ctl && op_opfield == 7'h0E && op_ctrl_addr == 5'h02
		|=> ##1 (interrupt_flags & $past(op_src_data[31:0], 2)) == $past(op_src_data[31:0], 2))
		else $error("flag set not visible");
	a_sconst_sext: assert property (tk && op_class == mcx_cls_signed_const_load_op && s_u
		|=> rf_we && rf_wdata == {8'h00, {16{$past(op_imm[15])}}, $past(op_imm)}) else $error("constant load wrong");
	a_upper_half: assert property (tk && s_u && op_class inside {mcx_cls_high_half_const_load_op,
		mcx_cls_low_to_high_const_load_op} |=> rf_wdata[31:0] == {$past(op_imm), $past(op_dst_old[15:0])})
		else $error("upper half load wrong");
	a_cond_fail: assert property (op_valid && !nop_busy && !op_cond_pass |=> !rf_we)
		else $error("write despite failed condition");
	a_nop_count: assert property (tk && op_class == mcx_cls_nop && op_nop_field == 4'h2 && !branch_done
		##1 (!branch_done)[*2] |-> $past(nop_busy) && nop_busy ##1 !nop_busy) else $error("idle length wrong");
	a_nop_branch: assert property (nop_busy && branch_done |=> !nop_busy)
		else $error("idle not ended by branch");

	c_copy: cover property (alu && op_opfield == 7'h02);
	c_idle: cover property (nop_busy && branch_done);
	c_flag: cover property (ctl && op_opfield == 7'h0E && op_ctrl_addr == 5'h02);
endmodule

bind mcx_unit mcx_unit_sva i_mcx_unit_sva (.core_clk, .sys_rst, .op_valid, .op_class, .op_unit, .op_opfield,
	.op_cond_pass, .op_src_data, .op_imm, .op_nop_field, .op_dst_old, .op_ctrl_addr, .branch_done, .rf_we,
	.rf_long, .rf_wdata, .op_illegal, .nop_busy, .addressing_mode_cfg, .interrupt_flags);

//--- sim/move_const_ctrl_xfer_unit_tb.sv
`timescale 1ns/1ns
module move_const_ctrl_xfer_unit_tb
	import mcx_pkg::*;
();
	logic core_clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, op_cond_pass = 1'b0, branch_done = 1'b0, tk = 1'b0;
	mcx_class_type op_class = mcx_cls_alu_op;
	mcx_unit_type op_unit = first_side_logic_unit;
	logic [6:0] op_opfield = 7'h00;
	logic [39:0] op_src_data = '0, rf_wdata;
	logic [15:0] op_imm = 16'h0000, k, k2;
	logic [3:0] op_nop_field = 4'h0;
	logic [31:0] op_dst_old = '0, hw_flag_set = '0, pc_e1 = '0, m, v;
	logic [4:0] op_dst_addr = 5'h00, op_ctrl_addr = 5'h00, rf_waddr, wa, a5;
	logic [4:0] qa [$];
	logic rf_we, rf_long, op_illegal, nop_busy;
	logic [31:0] addressing_mode_cfg, control_status, interrupt_flags, interrupt_enable_mask;
	logic [31:0] cr [32];
	logic [42:0] q [$], e;
	int bad_count = 0, checks = 0, cyc = 0, n;
	int fs [7] = '{2, 33, 18, 6, 22, 36, 7};

	mcx_unit i_mcx_unit (.core_clk, .sys_rst, .op_valid, .op_class, .op_unit, .op_opfield, .op_cond_pass,
		.op_src_data, .op_imm, .op_nop_field, .op_dst_old, .op_dst_addr, .op_ctrl_addr, .branch_done,
		.hw_flag_set, .pc_e1, .rf_we, .rf_long, .rf_waddr, .rf_wdata, .op_illegal, .nop_busy,
		.addressing_mode_cfg, .control_status, .interrupt_flags, .interrupt_enable_mask);

	task automatic conclude;
		$display("checks=%0d mismatches=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cmp(logic [42:0] got, logic [42:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// expectation {illegal, write, long, data}; control writes update the model at once
	function automatic logic [42:0] mdl(int c, int u, int f, bit cd, logic [39:0] s, logic [15:0] k,
		logic [31:0] o, int a);
		bit ok, lg, wr, su, lu;
		logic [39:0] d;
		ok = 1;
		lg = 0;
		wr = 0;
		d = '0;
		su = u == 2 || u == 3;
		lu = u < 2;
		case (c)
		0: if (lu && f == 2 || u > 3 && f == 18 || su && f == 6) d = {8'h00, s[31:0]};
			else if (lu && f == 33) {lg, d} = {1'b1, s};
			else if (su && f == 22 || lu && f == 6) d = {8'h00, 32'h0000_0000 - s[31:0]};
			else if (lu && f == 36) {lg, d} = {1'b1, 40'h00_0000_0000 - s};
			else ok = 0;
		1: begin
			wr = f == 14;
			ok = u == 3 && (wr || f == 15) && (a < 8 || a > 17 && a < 21 || a == 16 && !wr) && !(a == 3 && !wr);
			if (ok && !wr) d = {8'h00, a == 16 ? pc_e1 : cr[a]};
			if (ok && wr && cd)
				case (a)
				0: cr[0] = s[31:0] & 32'h03FF_FFFF;
				2: cr[2] |= s[31:0];
				3: cr[2] &= ~s[31:0];
				default: cr[a] = s[31:0];
				endcase
		end
		2: begin
			ok = su;
			d = {8'h00, {16{k[15]}}, k};
		end
		3, 4: begin
			ok = su;
			d = {8'h00, k, o[15:0]};
		end
		default: begin
			ok = a < 9;
			wr = 1;
		end
		endcase
		return {!ok, ok && cd && !wr, ok && cd && !wr && lg, d};
	endfunction

	task automatic drv(int c, int u, int f, bit cd, logic [39:0] s, logic [15:0] k, logic [31:0] o, int a);
		@(posedge core_clk);
		op_valid <= 1'b1;
		op_class <= mcx_class_type'(c);
		op_unit <= mcx_unit_type'(u);
		op_opfield <= 7'(f);
		op_cond_pass <= cd;
		op_src_data <= s;
		op_imm <= k;
		op_dst_old <= o;
		op_ctrl_addr <= 5'(a);
		op_nop_field <= 4'(a);
		wa = 5'($urandom);
		op_dst_addr <= wa;
		qa.push_back(wa);
		q.push_back(mdl(c, u, f, cd, s, k, o, a));
	endtask

	task automatic idle;
		@(posedge core_clk);
		op_valid <= 1'b0;
	endtask

	initial forever #50 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		#1;
		if (tk && q.size() > 0) begin
			e = q.pop_front();
			a5 = qa.pop_front();
			if (e[41]) cmp(43'(rf_waddr), 43'(a5));
			cmp({op_illegal, rf_we, rf_long, e[41] ? rf_wdata : 40'h0}, {e[42:40], e[41] ? e[39:0] : 40'h0});
		end
		tk = op_valid && !nop_busy && !sys_rst;
		cyc++;
		if (cyc > 2000) begin
			bad_count++;
			conclude();
		end
	end

	initial begin
		void'($urandom(32'h7FAB));
		pc_e1 = $urandom;
		foreach (cr[i]) cr[i] = '0;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1;
		cmp(43'(addressing_mode_cfg | control_status | interrupt_flags | interrupt_enable_mask), '0);
		foreach (fs[j])
			for (int u = 0; u < 6; u++)
				drv(0, u, fs[j], $urandom_range(3) != 0, 40'({$urandom, $urandom}), 0, 0, 0);
		for (int a = 0; a < 32; a++)
			drv(1, 3, 14, 1, 40'($urandom), 0, 0, a);
		idle;
		idle;
		#1;
		cmp(43'(addressing_mode_cfg), 43'(cr[0]));
		cmp(43'(control_status), 43'(cr[1]));
		cmp(43'(interrupt_enable_mask), 43'(cr[4]));
		cmp(43'(interrupt_flags), 43'(cr[2]));
		for (int a = 0; a < 32; a++)
			drv(1, 3, 15, 1, 0, 0, 0, a);
		drv(1, 2, 15, 1, 0, 0, 0, 0);
		drv(1, 3, 14, 0, 40'hFF_FFFF_FFFF, 0, 0, 4);
		drv(1, 3, 15, 1, 0, 0, 0, 4);
		for (int a = 2; a < 4; a++) begin
			m = cr[2];
			v = $urandom;
			drv(1, 3, 14, 1, 40'(v), 0, 0, a);
			idle;
			#1;
			cmp(43'(interrupt_flags), 43'(m));
			@(posedge core_clk);
			#1;
			cmp(43'(interrupt_flags), 43'(cr[2]));
		end
		v = $urandom;
		@(posedge core_clk);
		hw_flag_set <= v;
		@(posedge core_clk);
		hw_flag_set <= '0;
		#1;
		cr[2] |= v;
		cmp(43'(interrupt_flags), 43'(cr[2]));
		for (int i = 0; i < 4; i++) begin
			k = 16'($urandom);
			k2 = 16'($urandom);
			drv(2, 2 + i % 2, 0, 1, 0, k, 0, 0);
			drv(3 + i % 2, 2 + i % 2, 0, 1, 0, k2, {{16{k[15]}}, k}, 0);
		end
		drv(2, 0, 0, 1, 0, 16'h8001, 0, 0);
		// the copy is held on the inputs while the unit idles and must be taken once
		drv(5, 0, 0, 1, 0, 0, 0, 2);
		drv(0, 0, 2, 1, 40'h12_3456_789A, 0, 0, 0);
		#1;
		n = 0;
		while (nop_busy === 1'b1 && n < 20) begin
			n++;
			@(posedge core_clk);
			#1;
		end
		cmp(43'(n), 43'h2);
		drv(5, 0, 0, 1, 0, 0, 0, 9);
		drv(5, 0, 0, 1, 0, 0, 0, 0);
		idle;
		#1;
		cmp(43'(nop_busy), '0);
		drv(5, 0, 0, 1, 0, 0, 0, 6);
		idle;
		@(posedge core_clk);
		branch_done <= 1'b1;
		@(posedge core_clk);
		branch_done <= 1'b0;
		#1;
		cmp(43'(nop_busy), '0);
		repeat (3) idle;
		conclude();
	end
endmodule
